// [logic/sleep_ctrl_pkg.sv]
// types for the sleep-mode clock gating controller
package sleep_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE  = 2'b11
    } sleep_state_type;
    typedef struct packed {
        logic       req;
        logic [2:0] mode;
    } sleep_req_type;
endpackage

// [logic/sleep_ctrl_regs.svh]
// constants for the sleep-mode clock gating controller
`ifndef SLEEP_CTRL_REGS_SVH
`define SLEEP_CTRL_REGS_SVH
`define MODE_IDLE       3'h0
`define MODE_ADC_NR     3'h1
`define MODE_PWR_DOWN   3'h2
`define MODE_PWR_SAVE   3'h3
`define MODE_STANDBY    3'h6
`define DOM_CPU         0
`define DOM_OSC         1
`define DOM_SRAM        2
`define DOM_TIMER       3
`define DOM_SPI         4
`define DOM_IRQ         5
`define DOM_ATIMER      6
`define DOM_LCD         7
`define DOM_ADC         8
`define DOM_COUNT       9
`define EN_RUN          9'h1_FF
`define EN_IDLE         9'h1_FE
`define EN_ADC_NR       9'h1_C2
`define EN_PWR_SAVE     9'h0_C0
`define EN_PWR_DOWN     9'h0_00
`define EN_STANDBY      9'h0_02
`define OSC_START_NS    100
`define OSC_START_CYC   ((`OSC_START_NS + 9) / 10)
`endif

// [logic/sleep_mode_clock_gating.sv]
// sleep-mode clock gating controller top
`timescale 1ns/10ps
`include "sleep_ctrl_regs.svh"
module sleep_mode_clock_gating
    import sleep_ctrl_pkg::*;
(
    input  wire logic                  CLK,
    input  wire logic                  RESETN,
    input  wire logic                  SLEEP_REQ,
    input  wire logic [2:0]            SLEEP_MODE,
    input  wire logic                  IRQ,
    output logic      [`DOM_COUNT-1:0] CLK_EN,
    output logic                       SLEEPING
);
    localparam int unsigned START_CYC = `OSC_START_CYC;
    sleep_state_type    state_q, state_d;
    logic [`DOM_COUNT-1:0] en_q, en_d;
    logic [7:0]         cnt_q, cnt_d;
    logic [`DOM_COUNT-1:0] dec_en;
    logic               dec_valid;
    sleep_req_type      req;
    assign req.req  = SLEEP_REQ;
    assign req.mode = SLEEP_MODE;

    sleep_mode_decode u_dec (
        .mode  (req.mode),
        .en    (dec_en),
        .valid (dec_valid)
    );

    // oscillator off needs a restart delay before cpu clock returns
    wire osc_was_off = ~en_q[`DOM_OSC];
    wire take_req    = (state_q == ST_RUN) & req.req & dec_valid;

    always_comb begin
        state_d = state_q;
        en_d    = en_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_RUN: begin
                if (take_req) begin
                    state_d = ST_SLEEP;
                    en_d    = dec_en;
                end
            end
            ST_SLEEP: begin
                if (IRQ) begin
                    if (osc_was_off) begin
                        state_d = ST_WAKE;
                        en_d    = en_q | (`DOM_COUNT'(1) << `DOM_OSC);
                        cnt_d   = 8'(START_CYC);
                    end else begin
                        state_d = ST_RUN;
                        en_d    = `EN_RUN;
                    end
                end
            end
            ST_WAKE: begin
                if (cnt_q <= 8'h01) begin
                    state_d = ST_RUN;
                    en_d    = `EN_RUN;
                    cnt_d   = 8'h00;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            default: begin
                state_d = ST_RUN;
                en_d    = `EN_RUN;
                cnt_d   = 8'h00;
            end
        endcase
    end

    // register contents elsewhere survive: only enables change here
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= ST_RUN;
            en_q    <= `EN_RUN;
            cnt_q   <= 8'h00;
        end else begin
            state_q <= state_d;
            en_q    <= en_d;
            cnt_q   <= cnt_d;
        end
    end

    assign CLK_EN   = en_q;
    assign SLEEPING = (state_q != ST_RUN);

    AST_IDLE: assert property (@(posedge CLK) disable iff (!RESETN)
        take_req && SLEEP_MODE == `MODE_IDLE |=> CLK_EN == `EN_IDLE)
        else $error("idle enables wrong");
    AST_PDOWN: assert property (@(posedge CLK) disable iff (!RESETN)
        take_req && SLEEP_MODE == `MODE_PWR_DOWN |=> CLK_EN == 9'h0_00)
        else $error("power-down enables wrong");
    AST_PSAVE: assert property (@(posedge CLK) disable iff (!RESETN)
        take_req && SLEEP_MODE == `MODE_PWR_SAVE |=> CLK_EN[`DOM_ATIMER] && CLK_EN[`DOM_LCD]
        && !CLK_EN[`DOM_OSC])
        else $error("power-save enables wrong");
    AST_ADCNR: assert property (@(posedge CLK) disable iff (!RESETN)
        take_req && SLEEP_MODE == `MODE_ADC_NR |=> CLK_EN == `EN_ADC_NR)
        else $error("adc noise enables wrong");
    AST_STBY: assert property (@(posedge CLK) disable iff (!RESETN)
        take_req && SLEEP_MODE == `MODE_STANDBY |=> CLK_EN == 9'h0_02)
        else $error("standby enables wrong");
    AST_HOLD: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_SLEEP && !IRQ |=> $stable(CLK_EN) && SLEEPING)
        else $error("sleep left without wake event");
    AST_WAKE: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_SLEEP && IRQ |-> ##[1:11] CLK_EN == `EN_RUN)
        else $error("wake did not restore clocks");
    AST_NOREQ: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_RUN && !SLEEP_REQ |=> state_q == ST_RUN)
        else $error("slept without request");
    AST_MODES: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_RUN && SLEEP_REQ && !dec_valid |=> CLK_EN == `EN_RUN)
        else $error("invalid mode accepted");

    // counts restart cycles so AST_WAKE_BOUND and AST_WAKE_FULL need not unroll the delay
    logic [7:0] wake_len_q;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wake_len_q <= 8'h00;
        end else if (state_q == ST_WAKE) begin
            wake_len_q <= wake_len_q + 8'h01;
        end else begin
            wake_len_q <= 8'h00;
        end
    end

    AST_RUN_ALL: assert property (@(posedge CLK) disable iff (!RESETN)
        !SLEEPING |-> CLK_EN == `EN_RUN)
        else $error("run state with gated domain");

    AST_CPU_HALT: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_SLEEP |-> !CLK_EN[`DOM_CPU])
        else $error("cpu clocked while asleep");

    AST_IDLE_OSC: assert property (@(posedge CLK) disable iff (!RESETN)
        take_req && SLEEP_MODE == `MODE_IDLE |=> CLK_EN[`DOM_OSC])
        else $error("idle stopped the oscillator");

    AST_IDLE_KEEP: assert property (@(posedge CLK) disable iff (!RESETN)
        take_req && SLEEP_MODE == `MODE_IDLE |=> CLK_EN[`DOM_SRAM] && CLK_EN[`DOM_TIMER]
        && CLK_EN[`DOM_SPI] && CLK_EN[`DOM_IRQ])
        else $error("idle gated a kept domain");

    AST_PDOWN_SLEEP: assert property (@(posedge CLK) disable iff (!RESETN)
        take_req && SLEEP_MODE == `MODE_PWR_DOWN |=> SLEEPING)
        else $error("power-down not entered");

    AST_OSC_HOLD: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_SLEEP && !CLK_EN[`DOM_OSC] && !IRQ |=> !CLK_EN[`DOM_OSC])
        else $error("oscillator restarted without wake");

    AST_PSAVE_REST: assert property (@(posedge CLK) disable iff (!RESETN)
        take_req && SLEEP_MODE == `MODE_PWR_SAVE |=> !CLK_EN[`DOM_CPU]
        && !CLK_EN[`DOM_SRAM] && !CLK_EN[`DOM_SPI])
        else $error("power-save left a domain running");

    AST_ADCNR_KEEP: assert property (@(posedge CLK) disable iff (!RESETN)
        take_req && SLEEP_MODE == `MODE_ADC_NR |=> CLK_EN[`DOM_ADC]
        && CLK_EN[`DOM_ATIMER] && CLK_EN[`DOM_LCD])
        else $error("adc noise gated a kept domain");

    AST_ADCNR_IO: assert property (@(posedge CLK) disable iff (!RESETN)
        take_req && SLEEP_MODE == `MODE_ADC_NR |=> !CLK_EN[`DOM_SPI]
        && !CLK_EN[`DOM_TIMER] && !CLK_EN[`DOM_CPU])
        else $error("adc noise left io running");

    AST_STBY_OSC: assert property (@(posedge CLK) disable iff (!RESETN)
        take_req && SLEEP_MODE == `MODE_STANDBY |=> CLK_EN[`DOM_OSC] && !CLK_EN[`DOM_CPU])
        else $error("standby oscillator wrong");

    AST_FAST_WAKE: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_SLEEP && IRQ && CLK_EN[`DOM_OSC] |=> CLK_EN == `EN_RUN && !SLEEPING)
        else $error("running oscillator woke slowly");

    AST_SLOW_OSC: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_SLEEP && IRQ && !CLK_EN[`DOM_OSC] |=> CLK_EN[`DOM_OSC] && SLEEPING)
        else $error("oscillator not restarted first");

    AST_WAKE_CPU: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_WAKE |-> !CLK_EN[`DOM_CPU] && CLK_EN[`DOM_OSC])
        else $error("cpu clocked before oscillator settled");

    AST_WAKE_CNT: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_WAKE |-> cnt_q != 8'h00)
        else $error("restart counter empty while waiting");

    AST_WAKE_STAY: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_SLEEP && IRQ && !CLK_EN[`DOM_OSC] |-> ##10 SLEEPING)
        else $error("restart delay cut short");

    AST_WAKE_END: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_SLEEP && IRQ && !CLK_EN[`DOM_OSC] |-> ##11 !SLEEPING)
        else $error("restart delay too long");

    AST_WAKE_BOUND: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_WAKE |-> wake_len_q < 8'(START_CYC))
        else $error("restart wait overran");

    AST_WAKE_FULL: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_WAKE && wake_len_q == 8'(START_CYC - 1) |=> state_q == ST_RUN)
        else $error("restart wait not ended");

    AST_TAKE: assert property (@(posedge CLK) disable iff (!RESETN)
        take_req |=> SLEEPING)
        else $error("request not taken");

    AST_STATE_OK: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_RUN || state_q == ST_SLEEP || state_q == ST_WAKE)
        else $error("illegal state code");

    AST_RUN_CNT: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ST_RUN |-> cnt_q == 8'h00)
        else $error("stale restart count in run");
endmodule

// [logic/sleep_mode_decode.sv]
// maps a sleep mode onto the domain clock enables
`timescale 1ns/10ps
`include "sleep_ctrl_regs.svh"
module sleep_mode_decode
    import sleep_ctrl_pkg::*;
(
    input  wire logic [2:0]           mode,
    output logic      [`DOM_COUNT-1:0] en,
    output logic                      valid
);
    wire is_idle = (mode == `MODE_IDLE);
    wire is_adc  = (mode == `MODE_ADC_NR);
    wire is_pd   = (mode == `MODE_PWR_DOWN);
    wire is_ps   = (mode == `MODE_PWR_SAVE);
    wire is_sb   = (mode == `MODE_STANDBY);
    assign valid = is_idle | is_adc | is_pd | is_ps | is_sb;
    assign en = is_idle ? `EN_IDLE :
                is_adc  ? `EN_ADC_NR :
                is_ps   ? `EN_PWR_SAVE :
                is_pd   ? `EN_PWR_DOWN :
                is_sb   ? `EN_STANDBY :
                          `EN_RUN;
endmodule

// [tb/core_model.sv]
// processor core side issuing one-cycle sleep requests
`timescale 1ns/10ps
module core_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [2:0] sel,
    output logic            req,
    output logic [2:0]      mode
);
    initial req = 1'b0;
    initial mode = 3'h0;
    // mode only valid with req; flips otherwise so nothing leans on it
    always @(posedge clk) begin
        req <= go;
        mode <= go ? sel : ~mode;
    end
endmodule

// [tb/sleep_mode_clock_gating_tb.sv]
// bench for the sleep-mode clock gating controller
`timescale 1ns/10ps
`include "sleep_ctrl_regs.svh"
module sleep_mode_clock_gating_tb
    import sleep_ctrl_pkg::*;
;
    logic                  clk = 0, resetn = 0, go = 0, irq = 0, req;
    logic [2:0]            sel = 3'h0, mode;
    logic [`DOM_COUNT-1:0] clk_en, exp_en;
    logic                  sleeping;
    int                    n_errors = 0, samples_checked = 0, m, k, ok, slow;
    always #5 clk = ~clk;
    core_model core (.clk(clk), .go(go), .sel(sel), .req(req), .mode(mode));
    sleep_mode_clock_gating dut (.CLK(clk), .RESETN(resetn), .SLEEP_REQ(req),
        .SLEEP_MODE(mode), .IRQ(irq), .CLK_EN(clk_en), .SLEEPING(sleeping));
    function automatic logic [8:0] model_en(int md);
        case (md)
            0: return `EN_IDLE;
            1: return `EN_ADC_NR;
            2: return `EN_PWR_DOWN;
            3: return `EN_PWR_SAVE;
            6: return `EN_STANDBY;
            default: return `EN_RUN;
        endcase
    endfunction
    task automatic print_verdict;
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(logic [8:0] got, logic [8:0] want);
        samples_checked++;
        if (got !== want) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic req_sleep(int md);
        @(posedge clk) begin go <= 1'b1; sel <= md[2:0]; end
        @(posedge clk) go <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic wake;
        @(posedge clk) irq <= 1'b1;
        @(posedge clk) irq <= 1'b0;
        #1;
        chk(clk_en, slow ? (exp_en | 9'h0_02) : `EN_RUN);
        k = 0;
        while (sleeping !== 1'b0 && k < 50) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(k, slow ? `OSC_START_CYC : 0);
        chk(clk_en, `EN_RUN);
        if (k == 50) print_verdict();
    endtask
    initial begin
        void'($urandom(96));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            m = (i < 8) ? i : $urandom % 8;
            ok = m inside {0, 1, 2, 3, 6};
            slow = (m == 2 || m == 3);
            exp_en = model_en(m);
            req_sleep(m);
            chk(clk_en, exp_en);
            chk({8'h00, sleeping}, ok[8:0]);
            if (ok != 0) begin
                // a second request while asleep must not disturb the gating
                req_sleep(m ^ 1);
                chk(clk_en, exp_en);
                repeat ($urandom % 5) @(posedge clk);
                wake();
            end
            $display("test %0d mode %0d done", i, m);
        end
        slow = 1;
        req_sleep(2);
        @(posedge clk) resetn <= 1'b0;
        #1;
        chk(clk_en, `EN_RUN);
        chk({8'h00, sleeping}, 9'h0_00);
        print_verdict();
    end
endmodule
